// file: verification/testbench.sv
// Self-checking bench for the TLB translation block
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] cop_reg_i = 5'h0;
  logic cop_rd_i = 1'b0;
  logic cop_wr_i = 1'b0;
  logic op_valid_i = 1'b0;
  logic [63:0] cop_wdata_i = 64'h0;
  tlbat_pkg::tlbat_op_t op_i = tlbat_pkg::PROBE_OP;
  logic tr_req_i, tr_store_i, tr_done_o, tr_cached_o, tr_mapped_o, tr_write_ok_o;
  logic tr_page_valid_o, tr_miss_o, tr_invalid_o, tr_modify_o;
  logic [63:0] tr_vaddr_i, cop_rdata_o;
  logic [47:0] tr_paddr_o;
  logic [2:0] tr_cattr_o;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  tlbat_core_model u_core (.sys_clk_i(sys_clk_i), .tr_req_o(tr_req_i),
    .tr_vaddr_o(tr_vaddr_i), .tr_store_o(tr_store_i));
  tlbat_core u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tr_req_i(tr_req_i),
    .tr_vaddr_i(tr_vaddr_i), .tr_store_i(tr_store_i), .cop_reg_i(cop_reg_i),
    .cop_rd_i(cop_rd_i), .cop_wr_i(cop_wr_i), .cop_wdata_i(cop_wdata_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .cop_rdata_o(cop_rdata_o),
    .tr_done_o(tr_done_o), .tr_paddr_o(tr_paddr_o), .tr_cattr_o(tr_cattr_o),
    .tr_cached_o(tr_cached_o), .tr_mapped_o(tr_mapped_o),
    .tr_write_ok_o(tr_write_ok_o), .tr_page_valid_o(tr_page_valid_o),
    .tr_miss_o(tr_miss_o), .tr_invalid_o(tr_invalid_o), .tr_modify_o(tr_modify_o));
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] r, input logic [63:0] d);
    @(posedge sys_clk_i);
    cop_wr_i <= 1'b1;
    cop_reg_i <= r;
    cop_wdata_i <= d;
    @(posedge sys_clk_i);
    cop_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] r, input logic [63:0] exp);
    @(posedge sys_clk_i);
    cop_rd_i <= 1'b1;
    cop_reg_i <= r;
    @(posedge sys_clk_i);
    cop_rd_i <= 1'b0;
    #1;
    chk(cop_rdata_o, exp);
  endtask : rd
  task automatic op(input tlbat_pkg::tlbat_op_t o);
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
  endtask : op
  // Flags: mapped, cached, miss, invalid, modify, done
  task automatic tx(input logic [63:0] va, input logic st, input logic [47:0] pa,
                    input logic [5:0] fl, input logic [4:0] at);
    u_core.xlate(va, st);
    if (fl[3:2] == 2'b00) chk({16'h0, tr_paddr_o}, {16'h0, pa});
    chk({59'h0, tr_write_ok_o, tr_page_valid_o, tr_cattr_o}, {59'h0, at});
    chk({58'h0, tr_mapped_o, tr_cached_o, tr_miss_o, tr_invalid_o, tr_modify_o,
         tr_done_o}, {58'h0, fl});
  endtask : tx
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(5'h10, tlbat_pkg::CONFIG_RESET);
    rd(5'h04, 64'h0);
    tx(64'hffffffff_a0001234, 1'b0, 48'h1234, 6'h01, 5'h1a);
    tx(64'hffffffff_80005678, 1'b1, 48'h5678, 6'h01, 5'h1a);
    wr(5'h10, 64'h3);
    tx(64'hffffffff_80005678, 1'b0, 48'h5678, 6'h11, 5'h1b);
    $display("test segments done");
    wr(5'h02, 64'h0);
    wr(5'h03, 64'h0);
    wr(5'h05, 64'h0);
    for (int i = 0; i < 64; i++) begin
      wr(5'h0a, {45'h0, 6'(i), 13'h5});
      wr(5'h00, 64'(i));
      op(tlbat_pkg::WRITE_INDEXED_OP);
    end
    wr(5'h0a, 64'hffffffff_c0001f05);
    rd(5'h0a, 64'hc000ffff_c0000005);
    wr(5'h02, 64'hffff0000_0000401e);
    rd(5'h02, 64'h401e);
    wr(5'h03, 64'h4050);
    wr(5'h00, 64'h0);
    op(tlbat_pkg::WRITE_INDEXED_OP);
    wr(5'h0a, 64'hc000ffff_e0000005);
    wr(5'h02, 64'h801b);
    wr(5'h03, 64'h801b);
    wr(5'h00, 64'h1);
    op(tlbat_pkg::WRITE_INDEXED_OP);
    tx(64'hffffffff_c0000abc, 1'b0, 48'h100abc, 6'h31, 5'h1b);
    tx(64'hffffffff_c0000abc, 1'b1, 48'h100abc, 6'h31, 5'h1b);
    tx(64'hffffffff_c0001abc, 1'b0, 48'h101abc, 6'h25, 5'h02);
    tx(64'hffffffff_e0000123, 1'b1, 48'h200123, 6'h33, 5'h0b);
    wr(5'h0a, 64'h6);
    tx(64'hffffffff_c0000abc, 1'b0, 48'h0, 6'h29, 5'h02);
    tx(64'hffffffff_e0000123, 1'b0, 48'h200123, 6'h31, 5'h0b);
    $display("test translation done");
    wr(5'h0a, 64'hc000ffff_c0000005);
    op(tlbat_pkg::PROBE_OP);
    rd(5'h00, 64'h0);
    wr(5'h0a, 64'hc000ffff_c0000006);
    op(tlbat_pkg::PROBE_OP);
    rd(5'h00, 64'h8000_0000);
    wr(5'h00, 64'h1);
    op(tlbat_pkg::INDEXED_READ_OP);
    rd(5'h03, 64'h801b);
    rd(5'h0a, 64'hc000ffff_e0000005);
    wr(5'h06, 64'h2);
    wr(5'h0a, 64'hc000ffff_c0004005);
    wr(5'h02, 64'h401e);
    op(tlbat_pkg::WRITE_RANDOM_OP);
    tx(64'hffffffff_c0004010, 1'b0, 48'h100010, 6'h31, 5'h1b);
    tx(64'hffffffff_c0000abc, 1'b0, 48'h100abc, 6'h31, 5'h1b);
    wr(5'h0a, 64'h6);
    tx(64'hffffffff_c0004010, 1'b0, 48'h0, 6'h29, 5'h02);
    $display("test operations done");
    conclude();
  end
endmodule : testbench

// file: verification/tlbat_core_model.sv
// Fetch and load/store pipeline model issuing translation requests
`timescale 1ns/1ps
module tlbat_core_model (
  input  wire logic        sys_clk_i,
  output logic             tr_req_o,
  output logic [63:0]      tr_vaddr_o,
  output logic             tr_store_o
);
  initial begin
    tr_req_o = 1'b0;
    tr_vaddr_o = 64'h0;
    tr_store_o = 1'b0;
  end
  task automatic xlate(input logic [63:0] va, input logic st);
    @(posedge sys_clk_i);
    tr_req_o <= 1'b1;
    tr_vaddr_o <= va;
    tr_store_o <= st;
    @(posedge sys_clk_i);
    tr_req_o <= 1'b0;
    tr_vaddr_o <= ~va;
    tr_store_o <= ~st;
    #1;
  endtask : xlate
endmodule : tlbat_core_model

// file: verilog/tlbat_core.sv
// TLB address translation: compat segments, 64-entry TLB, coprocessor registers
`timescale 1ns/1ps
module tlbat_core #(
  parameter int          NUM_ENTRIES = tlbat_pkg::NUM_ENTRIES,
  parameter logic [63:0] PRID_VALUE  = 64'h0000_0000_0000_5a01 // Arbitrary value
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      tr_req_i,
  input  wire logic [63:0]               tr_vaddr_i,
  input  wire logic                      tr_store_i,
  input  wire logic [4:0]                cop_reg_i,
  input  wire logic                      cop_rd_i,
  input  wire logic                      cop_wr_i,
  input  wire logic [63:0]               cop_wdata_i,
  input  wire logic                      op_valid_i,
  input  wire tlbat_pkg::tlbat_op_t      op_i,
  output logic [63:0]                    cop_rdata_o,
  output logic                           tr_done_o,
  output logic [tlbat_pkg::PA_W-1:0]     tr_paddr_o,
  output logic [tlbat_pkg::CA_W-1:0]     tr_cattr_o,
  output logic                           tr_cached_o,
  output logic                           tr_mapped_o,
  output logic                           tr_write_ok_o,
  output logic                           tr_page_valid_o,
  output logic                           tr_miss_o,
  output logic                           tr_invalid_o,
  output logic                           tr_modify_o
);
  localparam int IDX_W  = $clog2(NUM_ENTRIES);
  localparam int PAGE_PAIR_NUMBER_W = tlbat_pkg::PAGE_PAIR_NUMBER_W;
  localparam int ASID_W = tlbat_pkg::ASID_W;
  localparam int MASK_W = tlbat_pkg::MASK_W;
  localparam int LO_W   = tlbat_pkg::LO_W;
  localparam int PFN_W  = tlbat_pkg::PFN_W;
  localparam int CA_W   = tlbat_pkg::CA_W;
  localparam int PA_W   = tlbat_pkg::PA_W;
  localparam int PG     = tlbat_pkg::PAGE_LSB;
  localparam int RG_W   = tlbat_pkg::REGION_W;

  typedef struct packed {
    logic [IDX_W-1:0]  index;
    logic              probe_fail;
    logic [IDX_W-1:0]  wired;
    logic [MASK_W-1:0] page_size_select;
    logic [RG_W-1:0]   hi_region;
    logic [PAGE_PAIR_NUMBER_W-1:0] hi_page_pair_number;
    logic [ASID_W-1:0] hi_asid;
    logic [LO_W-1:0]   lo_even;
    logic [LO_W-1:0]   lo_odd;
    logic [CA_W-1:0]   kseg_cache_attr_field;
    logic [63:0]       link_addr;
    logic [63:0]       tag_low;
    logic [63:0]       tag_high;
    logic [63:0]       rdata;
    logic              tr_done;
    logic [PA_W-1:0]   tr_paddr;
    logic [CA_W-1:0]   tr_cattr;
    logic              tr_cached;
    logic              tr_mapped;
    logic              tr_write_ok;
    logic              tr_page_valid;
    logic              tr_miss;
    logic              tr_invalid;
    logic              tr_modify;
  } tlbat_core_state_t;

  tlbat_core_state_t q;
  tlbat_core_state_t next_q;

  ////////////////////////////////////////////////////////////////////////////
  // TLB entry storage
  logic [RG_W-1:0]   ent_region [NUM_ENTRIES];
  logic [PAGE_PAIR_NUMBER_W-1:0] ent_page_pair_number   [NUM_ENTRIES];
  logic [MASK_W-1:0] ent_mask   [NUM_ENTRIES];
  logic [ASID_W-1:0] ent_asid   [NUM_ENTRIES];
  logic [LO_W-1:0]   ent_lo0    [NUM_ENTRIES];
  logic [LO_W-1:0]   ent_lo1    [NUM_ENTRIES];

  logic [NUM_ENTRIES-1:0] tr_hit;
  logic [NUM_ENTRIES-1:0] tr_odd;
  logic [NUM_ENTRIES-1:0] pr_hit;
  logic [IDX_W-1:0]       rand_val;
  logic                   ent_we;
  logic [IDX_W-1:0]       ent_widx;
  logic                   wired_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Comparators: one set for translation, one for probe
  for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_ent
    logic glob;
    assign glob = ent_lo0[e][tlbat_pkg::LO_G_BIT] & ent_lo1[e][tlbat_pkg::LO_G_BIT];
    tlbat_match_cell #(
      .PAGE_PAIR_NUMBER_W (PAGE_PAIR_NUMBER_W),
      .ASID_W (ASID_W),
      .MASK_W (MASK_W)
    ) u_tr_cell (
      .ent_region_i (ent_region[e]),
      .ent_page_pair_number_i   (ent_page_pair_number[e]),
      .ent_mask_i   (ent_mask[e]),
      .ent_asid_i   (ent_asid[e]),
      .ent_global_i (glob),
      .key_region_i (tr_vaddr_i[tlbat_pkg::HI_REGION_LSB +: RG_W]),
      .key_vpn_i    (tr_vaddr_i[PG +: PAGE_PAIR_NUMBER_W + 1]),
      .key_asid_i   (q.hi_asid),
      .hit_o        (tr_hit[e]),
      .odd_o        (tr_odd[e])
    );
    tlbat_match_cell #(
      .PAGE_PAIR_NUMBER_W (PAGE_PAIR_NUMBER_W),
      .ASID_W (ASID_W),
      .MASK_W (MASK_W)
    ) u_pr_cell (
      .ent_region_i (ent_region[e]),
      .ent_page_pair_number_i   (ent_page_pair_number[e]),
      .ent_mask_i   (ent_mask[e]),
      .ent_asid_i   (ent_asid[e]),
      .ent_global_i (glob),
      .key_region_i (q.hi_region),
      .key_vpn_i    ({q.hi_page_pair_number, 1'b0}),
      .key_asid_i   (q.hi_asid),
      .hit_o        (pr_hit[e]),
      .odd_o        ()
    );
  end

  tlbat_random #(
    .IDX_W (IDX_W)
  ) u_random (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .wired_i    (q.wired),
    .wired_wr_i (wired_wr),
    .value_o    (rand_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lookup decode
  logic              tr_any;
  logic [IDX_W-1:0]  tr_idx;
  logic              pr_any;
  logic [IDX_W-1:0]  pr_idx;
  logic [LO_W-1:0]   sel_lo;
  logic              sel_v;
  logic              sel_d;
  logic              compat;
  logic [1:0]        seg_sel;
  logic [PA_W-1:0]   off_mask;
  logic [63:0]       rd;

  always_comb begin
    tr_any = 1'b0;
    tr_idx = '0;
    pr_any = 1'b0;
    pr_idx = '0;
    for (int e = NUM_ENTRIES - 1; e >= 0; e--) begin
      if (tr_hit[e]) begin
        tr_any = 1'b1;
        tr_idx = IDX_W'(e);
      end
      if (pr_hit[e]) begin
        pr_any = 1'b1;
        pr_idx = IDX_W'(e);
      end
    end
    sel_lo   = tr_odd[tr_idx] ? ent_lo1[tr_idx] : ent_lo0[tr_idx];
    sel_v    = sel_lo[tlbat_pkg::LO_V_BIT];
    sel_d    = sel_lo[tlbat_pkg::LO_D_BIT];
    off_mask = PA_W'({ent_mask[tr_idx], {PG{1'b1}}});
    compat   = tr_vaddr_i[63:tlbat_pkg::COMPAT_LSB] == tlbat_pkg::COMPAT_TAG;
    seg_sel  = tr_vaddr_i[tlbat_pkg::SEG_SEL_LSB +: 2];
  end

  assign wired_wr = cop_wr_i && (cop_reg_i == tlbat_pkg::REG_WIRED);
  assign ent_we   = op_valid_i && !rst_i
                 && ((op_i == tlbat_pkg::WRITE_INDEXED_OP)
                  || (op_i == tlbat_pkg::WRITE_RANDOM_OP));
  assign ent_widx = (op_i == tlbat_pkg::WRITE_RANDOM_OP) ? rand_val : q.index;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    rd     = '0;

    // Translation
    next_q.tr_done = tr_req_i;
    if (tr_req_i) begin
      next_q.tr_miss    = 1'b0;
      next_q.tr_invalid = 1'b0;
      next_q.tr_modify  = 1'b0;
      if (compat && (seg_sel == tlbat_pkg::SEL_KERNEL_COMPAT_CACHED)) begin
        next_q.tr_mapped     = 1'b0;
        next_q.tr_paddr      = PA_W'(tr_vaddr_i[tlbat_pkg::SEG_OFF_W-1:0]);
        next_q.tr_cattr      = q.kseg_cache_attr_field;
        next_q.tr_write_ok   = 1'b1;
        next_q.tr_page_valid = 1'b1;
      end else if (compat && (seg_sel == tlbat_pkg::SEL_KERNEL_COMPAT_UNCACHED)) begin
        next_q.tr_mapped     = 1'b0;
        next_q.tr_paddr      = PA_W'(tr_vaddr_i[tlbat_pkg::SEG_OFF_W-1:0]);
        next_q.tr_cattr      = tlbat_pkg::CA_UNCACHED;
        next_q.tr_write_ok   = 1'b1;
        next_q.tr_page_valid = 1'b1;
      end else begin
        next_q.tr_mapped     = 1'b1;
        next_q.tr_paddr      = ({sel_lo[tlbat_pkg::LO_PFN_LSB +: PFN_W], {PG{1'b0}}}
                                & ~off_mask) | (tr_vaddr_i[PA_W-1:0] & off_mask);
        next_q.tr_cattr      = tr_any ? sel_lo[tlbat_pkg::LO_CA_LSB +: CA_W]
                                      : tlbat_pkg::CA_UNCACHED;
        next_q.tr_write_ok   = tr_any && sel_d;
        next_q.tr_page_valid = tr_any && sel_v;
        next_q.tr_miss       = !tr_any;
        next_q.tr_invalid    = tr_any && !sel_v;
        next_q.tr_modify     = tr_any && sel_v && tr_store_i && !sel_d;
      end
      // Uncached and accelerated codes bypass the cache
      next_q.tr_cached = (next_q.tr_cattr == tlbat_pkg::CA_CACHEABLE);
    end

    // Register read
    case (cop_reg_i)
      tlbat_pkg::REG_INDEX: begin
        rd[IDX_W-1:0] = q.index;
        rd[tlbat_pkg::INDEX_FAIL_BIT] = q.probe_fail;
      end
      tlbat_pkg::REG_RANDOM:           rd[IDX_W-1:0] = rand_val;
      tlbat_pkg::REG_ENTRY_LOW_EVEN:   rd[LO_W-1:0] = q.lo_even;
      tlbat_pkg::REG_ENTRY_LOW_ODD:    rd[LO_W-1:0] = q.lo_odd;
      tlbat_pkg::REG_PAGE_SIZE_SELECT: rd[tlbat_pkg::PM_MASK_LSB +: MASK_W] = q.page_size_select;
      tlbat_pkg::REG_WIRED:            rd[IDX_W-1:0] = q.wired;
      tlbat_pkg::REG_ENTRY_HIGH: begin
        rd[tlbat_pkg::HI_REGION_LSB +: RG_W] = q.hi_region;
        rd[tlbat_pkg::HI_PAGE_PAIR_NUMBER_LSB +: PAGE_PAIR_NUMBER_W] = q.hi_page_pair_number;
        rd[tlbat_pkg::HI_ASID_LSB +: ASID_W] = q.hi_asid;
      end
      tlbat_pkg::REG_PROC_ID: rd = PRID_VALUE;
      tlbat_pkg::REG_CONFIG: begin
        rd = tlbat_pkg::CONFIG_RESET;
        rd[tlbat_pkg::CFG_ATTR_LSB +: CA_W] = q.kseg_cache_attr_field;
      end
      tlbat_pkg::REG_LINK_ADDR:      rd = q.link_addr;
      tlbat_pkg::REG_CACHE_TAG_LOW:  rd = q.tag_low;
      tlbat_pkg::REG_CACHE_TAG_HIGH: rd = q.tag_high;
      default:                       rd = '0;
    endcase
    if (cop_rd_i) begin
      next_q.rdata = rd;
    end

    // Register write; padding and reserved bits are dropped
    if (cop_wr_i) begin
      case (cop_reg_i)
        tlbat_pkg::REG_INDEX: begin
          next_q.index      = cop_wdata_i[IDX_W-1:0];
          next_q.probe_fail = 1'b0;
        end
        tlbat_pkg::REG_ENTRY_LOW_EVEN: next_q.lo_even = cop_wdata_i[LO_W-1:0];
        tlbat_pkg::REG_ENTRY_LOW_ODD:  next_q.lo_odd  = cop_wdata_i[LO_W-1:0];
        tlbat_pkg::REG_PAGE_SIZE_SELECT:
          next_q.page_size_select = cop_wdata_i[tlbat_pkg::PM_MASK_LSB +: MASK_W];
        tlbat_pkg::REG_WIRED: next_q.wired = cop_wdata_i[IDX_W-1:0];
        tlbat_pkg::REG_ENTRY_HIGH: begin
          next_q.hi_region           = cop_wdata_i[tlbat_pkg::HI_REGION_LSB +: RG_W];
          next_q.hi_page_pair_number = cop_wdata_i[tlbat_pkg::HI_PAGE_PAIR_NUMBER_LSB +: PAGE_PAIR_NUMBER_W];
          next_q.hi_asid             = cop_wdata_i[tlbat_pkg::HI_ASID_LSB +: ASID_W];
        end
        tlbat_pkg::REG_CONFIG:
          next_q.kseg_cache_attr_field = cop_wdata_i[tlbat_pkg::CFG_ATTR_LSB +: CA_W];
        tlbat_pkg::REG_LINK_ADDR:      next_q.link_addr = cop_wdata_i;
        tlbat_pkg::REG_CACHE_TAG_LOW:  next_q.tag_low   = cop_wdata_i;
        tlbat_pkg::REG_CACHE_TAG_HIGH: next_q.tag_high  = cop_wdata_i;
        default: ;
      endcase
    end

    // TLB operations use register values from before this cycle's write
    if (op_valid_i) begin
      case (op_i)
        tlbat_pkg::PROBE_OP: begin
          next_q.probe_fail = !pr_any;
          if (pr_any) begin
            next_q.index = pr_idx;
          end
        end
        tlbat_pkg::INDEXED_READ_OP: begin
          next_q.hi_region           = ent_region[q.index];
          next_q.hi_page_pair_number = ent_page_pair_number[q.index];
          next_q.hi_asid             = ent_asid[q.index];
          next_q.page_size_select    = ent_mask[q.index];
          next_q.lo_even             = ent_lo0[q.index];
          next_q.lo_odd              = ent_lo1[q.index];
        end
        default: ;
      endcase
    end

    if (rst_i) begin
      next_q = '0;
      next_q.kseg_cache_attr_field = tlbat_pkg::CONFIG_RESET[tlbat_pkg::CFG_ATTR_LSB +: CA_W];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= next_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (ent_we) begin
      ent_region[ent_widx] <= q.hi_region;
      ent_page_pair_number[ent_widx]   <= q.hi_page_pair_number;
      ent_asid[ent_widx]   <= q.hi_asid;
      ent_mask[ent_widx]   <= q.page_size_select;
      ent_lo0[ent_widx]    <= q.lo_even;
      ent_lo1[ent_widx]    <= q.lo_odd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cop_rdata_o     = q.rdata;
  assign tr_done_o       = q.tr_done;
  assign tr_paddr_o      = q.tr_paddr;
  assign tr_cattr_o      = q.tr_cattr;
  assign tr_cached_o     = q.tr_cached;
  assign tr_mapped_o     = q.tr_mapped;
  assign tr_write_ok_o   = q.tr_write_ok;
  assign tr_page_valid_o = q.tr_page_valid;
  assign tr_miss_o       = q.tr_miss;
  assign tr_invalid_o    = q.tr_invalid;
  assign tr_modify_o     = q.tr_modify;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_cached_seg_attr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tr_req_i && compat && (seg_sel == tlbat_pkg::SEL_KERNEL_COMPAT_CACHED))
    |=> (tr_done_o && !tr_mapped_o && (tr_cattr_o == $past(q.kseg_cache_attr_field))))
    else $error("cached compat segment not bypassed");

  a_uncached_seg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tr_req_i && compat && (seg_sel == tlbat_pkg::SEL_KERNEL_COMPAT_UNCACHED))
    |=> (!tr_cached_o && !tr_mapped_o && !tr_miss_o))
    else $error("uncached compat segment went through tlb or cache");

  a_miss_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tr_req_i && !tr_any && !(compat && !seg_sel[1]))
    |=> (tr_mapped_o && tr_miss_o && !tr_cached_o && !tr_write_ok_o))
    else $error("missing entry not reported");

  a_invalid_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tr_req_i && tr_any && !sel_v && !(compat && !seg_sel[1]))
    |=> (tr_invalid_o && !tr_modify_o && !tr_miss_o))
    else $error("invalid page not reported");

  a_modify_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tr_req_i && tr_any && sel_v && tr_store_i && !sel_d && !(compat && !seg_sel[1]))
    |=> tr_modify_o)
    else $error("store to protected page not reported");

  a_cache_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tr_done_o |-> (tr_cached_o == (tr_cattr_o == tlbat_pkg::CA_CACHEABLE)))
    else $error("cache routing disagrees with attribute");

  a_fill_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cop_rd_i && (cop_reg_i == tlbat_pkg::REG_ENTRY_HIGH))
    |=> (cop_rdata_o[tlbat_pkg::HI_FILL_LSB +: tlbat_pkg::HI_FILL_W] == '0))
    else $error("entry high padding not zero");

  a_probe_result: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (op_valid_i && (op_i == tlbat_pkg::PROBE_OP) && !cop_wr_i)
    |=> (q.probe_fail == !$past(pr_any)))
    else $error("probe result wrong");
endmodule : tlbat_core

// file: verilog/tlbat_match_cell.sv
// One TLB entry comparator with even/odd page selection
`timescale 1ns/1ps
module tlbat_match_cell #(
  parameter int PAGE_PAIR_NUMBER_W = 35,
  parameter int ASID_W = 8,
  parameter int MASK_W = 12
) (
  input  wire logic [1:0]        ent_region_i,
  input  wire logic [PAGE_PAIR_NUMBER_W-1:0] ent_page_pair_number_i,
  input  wire logic [MASK_W-1:0] ent_mask_i,
  input  wire logic [ASID_W-1:0] ent_asid_i,
  input  wire logic              ent_global_i,
  input  wire logic [1:0]        key_region_i,
  input  wire logic [PAGE_PAIR_NUMBER_W:0]   key_vpn_i,
  input  wire logic [ASID_W-1:0] key_asid_i,
  output logic                   hit_o,
  output logic                   odd_o
);
  logic [PAGE_PAIR_NUMBER_W-1:0] care;

  always_comb begin
    care = '1;
    care[MASK_W-1:0] = ~ent_mask_i;
    // Valid flag takes no part in the match
    hit_o = (ent_region_i == key_region_i)
         && (((ent_page_pair_number_i ^ key_vpn_i[PAGE_PAIR_NUMBER_W:1]) & care) == '0)
         && (ent_global_i || (ent_asid_i == key_asid_i));
    odd_o = key_vpn_i[MASK_W];
    for (int i = MASK_W - 1; i >= 0; i--) begin
      if (!ent_mask_i[i]) begin
        odd_o = key_vpn_i[i];
      end
    end
  end
endmodule : tlbat_match_cell

// file: verilog/tlbat_pkg.sv
// Shared constants and types for the TLB address translation block
package tlbat_pkg;
  localparam int NUM_ENTRIES = 64;
  localparam int PAGE_PAIR_NUMBER_W      = 35;
  localparam int ASID_W      = 8;
  localparam int PFN_W       = 36;
  localparam int MASK_W      = 12;
  localparam int CA_W        = 3;
  localparam int LO_W        = 42;
  localparam int PA_W        = 48;
  localparam int REG_W       = 64;
  localparam int REGNUM_W    = 5;
  localparam int REGION_W    = 2;
  localparam int PAGE_LSB    = 12;
  localparam int SEG_OFF_W   = 29;

  // Coprocessor register numbers
  localparam logic [4:0] REG_INDEX            = 5'h00;
  localparam logic [4:0] REG_RANDOM           = 5'h01;
  localparam logic [4:0] REG_ENTRY_LOW_EVEN   = 5'h02;
  localparam logic [4:0] REG_ENTRY_LOW_ODD    = 5'h03;
  localparam logic [4:0] REG_PAGE_SIZE_SELECT = 5'h05;
  localparam logic [4:0] REG_WIRED            = 5'h06;
  localparam logic [4:0] REG_ENTRY_HIGH       = 5'h0a;
  localparam logic [4:0] REG_PROC_ID          = 5'h0f;
  localparam logic [4:0] REG_CONFIG           = 5'h10;
  localparam logic [4:0] REG_LINK_ADDR        = 5'h11;
  localparam logic [4:0] REG_CACHE_TAG_LOW    = 5'h1c;
  localparam logic [4:0] REG_CACHE_TAG_HIGH   = 5'h1d;

  // Entry high fields
  localparam int HI_REGION_LSB = 62;
  localparam int HI_FILL_LSB   = 48;
  localparam int HI_FILL_W     = 14;
  localparam int HI_PAGE_PAIR_NUMBER_LSB   = 13;
  localparam int HI_ASID_LSB   = 0;

  // Entry low fields
  localparam int LO_PFN_LSB = 6;
  localparam int LO_CA_LSB  = 3;
  localparam int LO_D_BIT   = 2;
  localparam int LO_V_BIT   = 1;
  localparam int LO_G_BIT   = 0;

  localparam int PM_MASK_LSB    = 13;
  localparam int INDEX_FAIL_BIT = 31;
  localparam int CFG_ATTR_LSB   = 0;

  // Compatibility segments: address bits 63:31 all ones, bits 30:29 select
  localparam int          COMPAT_LSB  = 31;
  localparam logic [32:0] COMPAT_TAG  = 33'h1_ffff_ffff;
  localparam int          SEG_SEL_LSB = 29;
  localparam logic [1:0]  SEL_KERNEL_COMPAT_CACHED   = 2'h0;
  localparam logic [1:0]  SEL_KERNEL_COMPAT_UNCACHED = 2'h1;

  // Cache attribute codes
  localparam logic [2:0] CA_UNCACHED  = 3'h2;
  localparam logic [2:0] CA_CACHEABLE = 3'h3;

  localparam logic [63:0] CONFIG_RESET = 64'h0000_0000_8003_4482;

  typedef enum logic [1:0] {
    PROBE_OP         = 2'b00,
    INDEXED_READ_OP  = 2'b01,
    WRITE_INDEXED_OP = 2'b10,
    WRITE_RANDOM_OP  = 2'b11
  } tlbat_op_t;
endpackage : tlbat_pkg

// file: verilog/tlbat_random.sv
// Random replacement index counter bounded below by the wired count
`timescale 1ns/1ps
module tlbat_random #(
  parameter int IDX_W = 6
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [IDX_W-1:0] wired_i,
  input  wire logic             wired_wr_i,
  output logic [IDX_W-1:0]      value_o
);
  typedef struct packed {
    logic [IDX_W-1:0] value;
  } tlbat_rand_state_t;

  localparam logic [IDX_W-1:0] TOP = '1;

  tlbat_rand_state_t q;
  tlbat_rand_state_t next_q;

  always_comb begin
    next_q = q;
    if (rst_i || wired_wr_i || (q.value <= wired_i)) begin
      next_q.value = TOP;
    end else begin
      next_q.value = q.value - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= next_q;
  end

  assign value_o = q.value;

  a_random_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    value_o >= wired_i)
    else $error("random index below wired count");

  a_random_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!wired_wr_i && (value_o > wired_i)) |=> (value_o == $past(value_o) - 1'b1))
    else $error("random index did not step down");
endmodule : tlbat_random
